// ### core/sdma_pkg.sv
// shared constants and types of the direct-mode stream dma engine
package sdma_pkg;
	// data path and stream sideband widths
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 32;
	localparam int unsigned STRB_W = 4;
	localparam int unsigned USER_W = 4;
	localparam int unsigned ID_W = 5;
	localparam int unsigned DEST_W = 5;
	localparam int unsigned REG_AW = 8;
	// sideband values every produced beat carries
	localparam logic [STRB_W-1:0] STRB_ALL = 4'hF;
	localparam logic [STRB_W-1:0] KEEP_ALL = 4'hF;
	localparam logic [USER_W-1:0] USER_ZERO = 4'h0;
	localparam logic [ID_W-1:0] ID_ZERO = 5'h00;
	localparam logic [DEST_W-1:0] DEST_ZERO = 5'h00;
	// register byte offsets
	localparam logic [REG_AW-1:0] OFF_CTRL = 8'h00;
	localparam logic [REG_AW-1:0] OFF_STAT = 8'h04;
	localparam logic [REG_AW-1:0] OFF_SEND_SRC = 8'h18;
	localparam logic [REG_AW-1:0] OFF_SEND_LEN = 8'h28;
	localparam logic [REG_AW-1:0] OFF_RECV_DST = 8'h48;
	localparam logic [REG_AW-1:0] OFF_RECV_LEN = 8'h58;
	localparam logic [REG_AW-1:0] OFF_RECV_CNT = 8'h5C;
	// control and status bit positions
	localparam int unsigned CTRL_SEND_RUN = 0;
	localparam int unsigned CTRL_RECV_RUN = 1;
	localparam int unsigned ST_SEND_IDLE = 0;
	localparam int unsigned ST_RECV_IDLE = 1;
	localparam int unsigned ST_SEND_ERR = 2;
	localparam int unsigned ST_RECV_ERR = 3;
	localparam int unsigned ST_CHAIN_MODE = 4;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	// single-beat memory bursts of one aligned word
	localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
	localparam logic [7:0] AX_LEN_ONE = 8'h00;
	localparam logic [2:0] AX_SIZE_WORD = 3'h2;
	localparam logic [1:0] AX_BURST_INCR = 2'h1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	// matrix layout carried by the streams
	localparam int unsigned MATRIX_DIMENSION = 32;
	typedef enum logic [1:0] {
		SDMA_MM_IDLE = 2'b00,
		SDMA_MM_ADDR = 2'b01,
		SDMA_MM_DATA = 2'b10,
		SDMA_MM_SEND = 2'b11
	} sdma_mm_state_t;
	typedef enum logic [1:0] {
		SDMA_S2_IDLE = 2'b00,
		SDMA_S2_RECV = 2'b01,
		SDMA_S2_WRITE = 2'b10
	} sdma_s2_state_t;
endpackage : sdma_pkg

// ### core/sdma_stream_to_memory_channel.sv
// stream-to-memory channel: stream beats written to memory one word each
`timescale 1ns/10ps
`default_nettype none
module sdma_recv (
	input wire logic core_clk,
	input wire logic rst_b,
	sdma_recv_if.chan ctl,
	input wire logic [31:0] s_tdata,
	input wire logic [3:0] s_tstrb,
	input wire logic [3:0] s_tkeep,
	input wire logic [3:0] s_tuser,
	input wire logic [4:0] s_tid,
	input wire logic [4:0] s_tdest,
	input wire logic s_tlast,
	input wire logic s_tvalid,
	output logic s_tready,
	output logic [31:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready
);
	sdma_pkg::sdma_s2_state_t state_r;
	logic [31:0] addr_r;
	logic [31:0] remain_r;
	logic [31:0] count_r;
	logic last_r;
	logic done_r;
	logic err_r;
	logic take;

	// sidebands are left unread and never alter the stored word
	assign take = s_tvalid && s_tready;
	assign ctl.idle = (state_r == sdma_pkg::SDMA_S2_IDLE);
	assign ctl.done = done_r;
	assign ctl.err = err_r;
	assign ctl.count = count_r;

	// one beat in flight: ready drops until its write is answered
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state_r <= sdma_pkg::SDMA_S2_IDLE;
			s_tready <= 1'b0;
			awvalid <= 1'b0;
			wvalid <= 1'b0;
			bready <= 1'b0;
			awaddr <= sdma_pkg::WORD_ZERO;
			wdata <= sdma_pkg::WORD_ZERO;
			addr_r <= sdma_pkg::WORD_ZERO;
			remain_r <= sdma_pkg::WORD_ZERO;
			count_r <= sdma_pkg::WORD_ZERO;
			last_r <= 1'b0;
			done_r <= 1'b0;
			err_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			err_r <= 1'b0;
			unique case (state_r)
			sdma_pkg::SDMA_S2_IDLE: begin
				// length write arms the channel
				if (ctl.start && ctl.run) begin
					addr_r <= ctl.dst;
					remain_r <= ctl.len;
					count_r <= sdma_pkg::WORD_ZERO;
					s_tready <= 1'b1;
					state_r <= sdma_pkg::SDMA_S2_RECV;
				end
			end
			sdma_pkg::SDMA_S2_RECV: begin
				if (!ctl.run && !take) begin
					s_tready <= 1'b0;
					state_r <= sdma_pkg::SDMA_S2_IDLE;
				end else if (take) begin
					s_tready <= 1'b0;
					wdata <= s_tdata;
					last_r <= s_tlast;
					awaddr <= addr_r;
					awvalid <= 1'b1;
					wvalid <= 1'b1;
					bready <= 1'b1;
					state_r <= sdma_pkg::SDMA_S2_WRITE;
				end
			end
			sdma_pkg::SDMA_S2_WRITE: begin
				if (awready) begin
					awvalid <= 1'b0;
				end
				if (wready) begin
					wvalid <= 1'b0;
				end
				if (bvalid) begin
					bready <= 1'b0;
					addr_r <= addr_r + sdma_pkg::WORD_BYTES;
					remain_r <= (remain_r > sdma_pkg::WORD_BYTES) ?
						remain_r - sdma_pkg::WORD_BYTES : sdma_pkg::WORD_ZERO;
					count_r <= count_r + sdma_pkg::WORD_BYTES;
					if (bresp != sdma_pkg::RESP_OKAY) begin
						err_r <= 1'b1;
						state_r <= sdma_pkg::SDMA_S2_IDLE;
					end else if (last_r || remain_r <= sdma_pkg::WORD_BYTES)
					begin
						done_r <= 1'b1;
						state_r <= sdma_pkg::SDMA_S2_IDLE;
					end else begin
						s_tready <= 1'b1;
						state_r <= sdma_pkg::SDMA_S2_RECV;
					end
				end
			end
			default: state_r <= sdma_pkg::SDMA_S2_IDLE;
			endcase
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	chk_beat_no_dup: assert property (take |=> !s_tready)
		else $error("stream ready stayed high after a taken beat");
	chk_beat_to_mem: assert property (
		take |=> wvalid && awvalid && wdata == $past(s_tdata))
		else $error("taken beat not offered to memory unchanged");
	chk_len_arms: assert property (
		ctl.start && ctl.run && state_r == sdma_pkg::SDMA_S2_IDLE
		|=> s_tready)
		else $error("length write did not open the receive side");
endmodule : sdma_recv
`default_nettype wire

// ### core/sdma_stream_to_memory_channel_if.sv
// control and status link between register block and receive channel
`timescale 1ns/10ps
`default_nettype none
interface sdma_recv_if;
	logic run;
	logic start;
	logic [31:0] dst;
	logic [31:0] len;
	logic idle;
	logic done;
	logic err;
	logic [31:0] count;
	modport ctl (output run, start, dst, len, input idle, done, err, count);
	modport chan (input run, start, dst, len, output idle, done, err, count);
endinterface : sdma_recv_if
`default_nettype wire

// ### core/sdma_top.sv
// direct-mode stream dma engine: registers, memory-to-stream, receive path
// Functional notes
// - of the chained and direct modes only direct mode is built here.
// - ports are a register port, memory read and write masters, a data stream out and in, a control stream out and a status stream in.
// - the send channel reads memory words and hands them on as stream beats.
// - the receive channel takes stream beats and writes them to memory.
// - transfers start only by register writes of control, address and length.
// - the send length is a byte count and writing it starts the transfer.
// - the receive length is the buffer size in bytes and writing it starts reception.
// - each beat carries one float word as its raw bit pattern.
// - produced beats drive strobe and keep all ones and user, id and dest zero.
// - last is high on the final beat of a packet only.
// - sidebands are four bits of user, five of id, five of dest, with 32 data bits.
// - sidebands of a received beat never change its data word.
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module sdma_top (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic [31:0] m_araddr,
	output logic [7:0] m_arlen,
	output logic [2:0] m_arsize,
	output logic [1:0] m_arburst,
	output logic m_arvalid,
	input wire logic m_arready,
	input wire logic [31:0] m_rdata,
	input wire logic [1:0] m_rresp,
	input wire logic m_rlast,
	input wire logic m_rvalid,
	output logic m_rready,
	output logic [31:0] m_awaddr,
	output logic [7:0] m_awlen,
	output logic [2:0] m_awsize,
	output logic [1:0] m_awburst,
	output logic m_awvalid,
	input wire logic m_awready,
	output logic [31:0] m_wdata,
	output logic [3:0] m_wstrb,
	output logic m_wlast,
	output logic m_wvalid,
	input wire logic m_wready,
	input wire logic [1:0] m_bresp,
	input wire logic m_bvalid,
	output logic m_bready,
	output logic [31:0] send_tdata,
	output logic [3:0] send_tstrb,
	output logic [3:0] send_tkeep,
	output logic [3:0] send_tuser,
	output logic [4:0] send_tid,
	output logic [4:0] send_tdest,
	output logic send_tlast,
	output logic send_tvalid,
	input wire logic send_tready,
	input wire logic [31:0] recv_tdata,
	input wire logic [3:0] recv_tstrb,
	input wire logic [3:0] recv_tkeep,
	input wire logic [3:0] recv_tuser,
	input wire logic [4:0] recv_tid,
	input wire logic [4:0] recv_tdest,
	input wire logic recv_tlast,
	input wire logic recv_tvalid,
	output logic recv_tready,
	output logic [31:0] ctl_tdata,
	output logic ctl_tlast,
	output logic ctl_tvalid,
	input wire logic ctl_tready,
	input wire logic [31:0] sts_tdata,
	input wire logic sts_tlast,
	input wire logic sts_tvalid,
	output logic sts_tready
);
	sdma_recv_if s2_if ();
	sdma_pkg::sdma_mm_state_t mm_state_r;
	logic [1:0] ctrl_r;
	logic [31:0] mm_src_r;
	logic [31:0] mm_len_r;
	logic [31:0] s2_dst_r;
	logic [31:0] s2_len_r;
	logic [31:0] mm_addr_r;
	logic [31:0] mm_remain_r;
	logic mm_done_r;
	logic mm_fail_r;
	logic mm_err_r;
	logic s2_err_r;
	logic mm_start;
	logic wr_stat;
	logic [31:0] status_w;
	logic [7:0] ax_len_r;
	logic [2:0] ax_size_r;
	logic [1:0] ax_burst_r;
	logic [3:0] wstrb_r;
	logic wlast_r;

	// only the direct mode exists; nothing ever fetches descriptors
	assign mm_start = reg_wr && reg_addr == sdma_pkg::OFF_SEND_LEN &&
		ctrl_r[sdma_pkg::CTRL_SEND_RUN] && reg_wdata != sdma_pkg::WORD_ZERO &&
		mm_state_r == sdma_pkg::SDMA_MM_IDLE;
	assign wr_stat = reg_wr && reg_addr == sdma_pkg::OFF_STAT;

	// receive channel controls straight from the register port
	assign s2_if.run = ctrl_r[sdma_pkg::CTRL_RECV_RUN];
	assign s2_if.start = reg_wr && reg_addr == sdma_pkg::OFF_RECV_LEN &&
		reg_wdata != sdma_pkg::WORD_ZERO;
	assign s2_if.dst = s2_dst_r;
	assign s2_if.len = reg_wdata;

	// control and address/length registers
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			ctrl_r <= sdma_pkg::CTRL_RST;
			mm_src_r <= sdma_pkg::WORD_ZERO;
			mm_len_r <= sdma_pkg::WORD_ZERO;
			s2_dst_r <= sdma_pkg::WORD_ZERO;
			s2_len_r <= sdma_pkg::WORD_ZERO;
		end else if (reg_wr) begin
			case (reg_addr)
			sdma_pkg::OFF_CTRL: ctrl_r <= reg_wdata[1:0];
			sdma_pkg::OFF_SEND_SRC: mm_src_r <= reg_wdata;
			sdma_pkg::OFF_SEND_LEN: mm_len_r <= reg_wdata;
			sdma_pkg::OFF_RECV_DST: s2_dst_r <= reg_wdata;
			sdma_pkg::OFF_RECV_LEN: s2_len_r <= reg_wdata;
			default: ctrl_r <= ctrl_r;
			endcase
		end
	end

	// sticky error flags, write one to clear; a new error wins the clear
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			mm_err_r <= 1'b0;
			s2_err_r <= 1'b0;
		end else begin
			mm_err_r <= mm_fail_r ||
				(mm_err_r && !(wr_stat && reg_wdata[sdma_pkg::ST_SEND_ERR]));
			s2_err_r <= s2_if.err ||
				(s2_err_r && !(wr_stat && reg_wdata[sdma_pkg::ST_RECV_ERR]));
		end
	end

	// status word; chained-mode flag always reads zero
	always_comb begin
		status_w = sdma_pkg::WORD_ZERO;
		status_w[sdma_pkg::ST_SEND_IDLE] = mm_state_r == sdma_pkg::SDMA_MM_IDLE;
		status_w[sdma_pkg::ST_RECV_IDLE] = s2_if.idle;
		status_w[sdma_pkg::ST_SEND_ERR] = mm_err_r;
		status_w[sdma_pkg::ST_RECV_ERR] = s2_err_r;
		status_w[sdma_pkg::ST_CHAIN_MODE] = 1'b0;
	end

	// read data registered, valid only in the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			reg_rdata <= sdma_pkg::WORD_ZERO;
		end else if (reg_rd) begin
			case (reg_addr)
			sdma_pkg::OFF_CTRL: reg_rdata <= {30'h0000_0000, ctrl_r};
			sdma_pkg::OFF_STAT: reg_rdata <= status_w;
			sdma_pkg::OFF_SEND_SRC: reg_rdata <= mm_src_r;
			sdma_pkg::OFF_SEND_LEN: reg_rdata <= mm_len_r;
			sdma_pkg::OFF_RECV_DST: reg_rdata <= s2_dst_r;
			sdma_pkg::OFF_RECV_LEN: reg_rdata <= s2_len_r;
			sdma_pkg::OFF_RECV_CNT: reg_rdata <= s2_if.count;
			default: reg_rdata <= sdma_pkg::WORD_ZERO;
			endcase
		end else begin
			reg_rdata <= sdma_pkg::WORD_ZERO;
		end
	end

	// fixed burst attributes: one aligned word per memory transaction
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			ax_len_r <= sdma_pkg::AX_LEN_ONE;
			ax_size_r <= sdma_pkg::AX_SIZE_WORD;
			ax_burst_r <= sdma_pkg::AX_BURST_INCR;
			wstrb_r <= sdma_pkg::STRB_ALL;
			wlast_r <= 1'b1;
		end else begin
			ax_len_r <= sdma_pkg::AX_LEN_ONE;
			ax_size_r <= sdma_pkg::AX_SIZE_WORD;
			ax_burst_r <= sdma_pkg::AX_BURST_INCR;
			wstrb_r <= sdma_pkg::STRB_ALL;
			wlast_r <= 1'b1;
		end
	end
	assign m_arlen = ax_len_r;
	assign m_arsize = ax_size_r;
	assign m_arburst = ax_burst_r;
	assign m_awlen = ax_len_r;
	assign m_awsize = ax_size_r;
	assign m_awburst = ax_burst_r;
	assign m_wstrb = wstrb_r;
	assign m_wlast = wlast_r;

	// constant sidebands of produced beats; control stream never sends,
	// status stream is drained and dropped since nothing here uses it
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			send_tstrb <= sdma_pkg::STRB_ALL;
			send_tkeep <= sdma_pkg::KEEP_ALL;
			send_tuser <= sdma_pkg::USER_ZERO;
			send_tid <= sdma_pkg::ID_ZERO;
			send_tdest <= sdma_pkg::DEST_ZERO;
			ctl_tdata <= sdma_pkg::WORD_ZERO;
			ctl_tlast <= 1'b0;
			ctl_tvalid <= 1'b0;
			sts_tready <= 1'b0;
		end else begin
			send_tstrb <= sdma_pkg::STRB_ALL;
			send_tkeep <= sdma_pkg::KEEP_ALL;
			send_tuser <= sdma_pkg::USER_ZERO;
			send_tid <= sdma_pkg::ID_ZERO;
			send_tdest <= sdma_pkg::DEST_ZERO;
			ctl_tdata <= sdma_pkg::WORD_ZERO;
			ctl_tlast <= 1'b0;
			ctl_tvalid <= 1'b0;
			sts_tready <= 1'b1;
		end
	end

	// memory-to-stream: read one word, send it, repeat; run-bit clear is
	// honoured at beat boundaries since a raised valid may not be withdrawn
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			mm_state_r <= sdma_pkg::SDMA_MM_IDLE;
			mm_addr_r <= sdma_pkg::WORD_ZERO;
			mm_remain_r <= sdma_pkg::WORD_ZERO;
			m_araddr <= sdma_pkg::WORD_ZERO;
			m_arvalid <= 1'b0;
			m_rready <= 1'b0;
			send_tdata <= sdma_pkg::WORD_ZERO;
			send_tlast <= 1'b0;
			send_tvalid <= 1'b0;
			mm_done_r <= 1'b0;
			mm_fail_r <= 1'b0;
		end else begin
			mm_done_r <= 1'b0;
			mm_fail_r <= 1'b0;
			unique case (mm_state_r)
			sdma_pkg::SDMA_MM_IDLE: begin
				if (mm_start) begin
					mm_addr_r <= mm_src_r;
					mm_remain_r <= reg_wdata;
					m_araddr <= mm_src_r;
					m_arvalid <= 1'b1;
					mm_state_r <= sdma_pkg::SDMA_MM_ADDR;
				end
			end
			sdma_pkg::SDMA_MM_ADDR: begin
				if (m_arready) begin
					m_arvalid <= 1'b0;
					m_rready <= 1'b1;
					mm_state_r <= sdma_pkg::SDMA_MM_DATA;
				end
			end
			sdma_pkg::SDMA_MM_DATA: begin
				if (m_rvalid) begin
					m_rready <= 1'b0;
					if (m_rresp != sdma_pkg::RESP_OKAY) begin
						mm_fail_r <= 1'b1;
						mm_state_r <= sdma_pkg::SDMA_MM_IDLE;
					end else begin
						send_tdata <= m_rdata;
						// closing beat of the byte count
						send_tlast <= mm_remain_r <= sdma_pkg::WORD_BYTES;
						send_tvalid <= 1'b1;
						mm_state_r <= sdma_pkg::SDMA_MM_SEND;
					end
				end
			end
			sdma_pkg::SDMA_MM_SEND: begin
				if (send_tready) begin
					send_tvalid <= 1'b0;
					send_tlast <= 1'b0;
					mm_addr_r <= mm_addr_r + sdma_pkg::WORD_BYTES;
					mm_remain_r <= mm_remain_r - sdma_pkg::WORD_BYTES;
					if (send_tlast) begin
						mm_done_r <= 1'b1;
						mm_state_r <= sdma_pkg::SDMA_MM_IDLE;
					end else if (!ctrl_r[sdma_pkg::CTRL_SEND_RUN]) begin
						mm_state_r <= sdma_pkg::SDMA_MM_IDLE;
					end else begin
						m_araddr <= mm_addr_r + sdma_pkg::WORD_BYTES;
						m_arvalid <= 1'b1;
						mm_state_r <= sdma_pkg::SDMA_MM_ADDR;
					end
				end
			end
			endcase
		end
	end

	sdma_recv u_recv (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.ctl(s2_if.chan),
		.s_tdata(recv_tdata),
		.s_tstrb(recv_tstrb),
		.s_tkeep(recv_tkeep),
		.s_tuser(recv_tuser),
		.s_tid(recv_tid),
		.s_tdest(recv_tdest),
		.s_tlast(recv_tlast),
		.s_tvalid(recv_tvalid),
		.s_tready(recv_tready),
		.awaddr(m_awaddr),
		.awvalid(m_awvalid),
		.awready(m_awready),
		.wdata(m_wdata),
		.wvalid(m_wvalid),
		.wready(m_wready),
		.bresp(m_bresp),
		.bvalid(m_bvalid),
		.bready(m_bready)
	);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	chk_len_starts_read: assert property (mm_start |=>
		m_arvalid && m_araddr == $past(mm_src_r))
		else $error("length write did not issue the first read");
	chk_no_start_norun: assert property (
		mm_state_r == sdma_pkg::SDMA_MM_IDLE && !mm_start
		|=> mm_state_r == sdma_pkg::SDMA_MM_IDLE)
		else $error("send channel left idle without a length write");
	chk_ar_hold: assert property (m_arvalid && !m_arready |=>
		m_arvalid && $stable(m_araddr))
		else $error("read request withdrawn or changed before accept");
	chk_beat_hold: assert property (
		send_tvalid && !send_tready |=> send_tvalid &&
		$stable(send_tdata) && $stable(send_tlast))
		else $error("stream beat changed while stalled");
	chk_raw_word: assert property (
		m_rvalid && m_rready && m_rresp == sdma_pkg::RESP_OKAY
		|=> send_tvalid && send_tdata == $past(m_rdata))
		else $error("read word not forwarded unchanged");
	chk_side_const: assert property (send_tvalid |->
		send_tkeep == sdma_pkg::KEEP_ALL && send_tstrb == sdma_pkg::STRB_ALL &&
		send_tuser == sdma_pkg::USER_ZERO && send_tid == sdma_pkg::ID_ZERO &&
		send_tdest == sdma_pkg::DEST_ZERO)
		else $error("produced beat carries wrong sideband");
	chk_last_final: assert property (send_tvalid |->
		send_tlast == (mm_remain_r <= sdma_pkg::WORD_BYTES))
		else $error("last flag does not match the closing beat");
	chk_read_latency: assert property (reg_rd &&
		reg_addr == sdma_pkg::OFF_SEND_SRC |=> reg_rdata == $past(mm_src_r))
		else $error("register read data wrong in the following cycle");
	cov_mm_done: cover property (mm_done_r);
	cov_s2_done: cover property (s2_if.done);
	cov_stall: cover property (send_tvalid && !send_tready ##1 send_tready);
endmodule : sdma_top
`default_nettype wire

// ### verification/sdma_mem_model.sv
// memory model answering single-beat word reads and writes
`timescale 1ns/10ps
`default_nettype none
module sdma_mem_model (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic slow,
	input wire logic [31:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output var logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rlast,
	output var logic rvalid,
	input wire logic rready,
	input wire logic [31:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output var logic bvalid,
	input wire logic bready
);
	logic [31:0] mem [2048];
	logic [31:0] ra;
	logic pend;
	logic [1:0] ph;
	logic go;
	// slow mode answers only one cycle in three
	assign go = !slow || (ph == 2'h0);
	assign arready = rst_b && go && !pend;
	// address and data taken together, so one write is never split
	assign awready = rst_b && go && awvalid && wvalid && !bvalid;
	assign wready = awready;
	// idle response lines show a non-okay pattern, not a stale okay
	assign rresp = rvalid ? 2'h0 : 2'h3;
	assign rlast = rvalid;
	assign bresp = bvalid ? 2'h0 : 2'h3;
	// read and write channel state
	// plain always: the bench preloads mem through the hierarchy
	always @(posedge core_clk) begin
		ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
		if (!rst_b) begin
			pend <= 1'b0;
			rvalid <= 1'b0;
			bvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			ph <= 2'h0;
		end else begin
			if (arvalid && arready) begin
				ra <= araddr;
				pend <= 1'b1;
			end
			if (pend && go && !rvalid) begin
				rvalid <= 1'b1;
				rdata <= mem[ra[12:2]];
			end
			if (rvalid && rready) begin
				rvalid <= 1'b0;
				pend <= 1'b0;
				rdata <= ~rdata;
			end
			if (awready) begin
				mem[awaddr[12:2]] <= wdata;
				bvalid <= 1'b1;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end
endmodule : sdma_mem_model
`default_nettype wire

// ### verification/tb_stream_dma_direct_mode.sv
// self-checking bench of the direct-mode stream dma engine
`timescale 1ns/10ps
`default_nettype none
module tb_stream_dma_direct_mode;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata, m_araddr, m_rdata, m_awaddr, m_wdata, send_tdata;
	logic [31:0] ctl_tdata, rv, bv;
	logic [7:0] m_arlen, m_awlen;
	logic [2:0] m_arsize, m_awsize;
	logic [1:0] m_arburst, m_awburst, m_rresp, m_bresp;
	logic [3:0] m_wstrb, send_tstrb, send_tkeep, send_tuser;
	logic [4:0] send_tid, send_tdest;
	logic m_arvalid, m_arready, m_rlast, m_rvalid, m_rready, m_awvalid;
	logic m_awready, m_wlast, m_wvalid, m_wready, m_bvalid, m_bready;
	logic send_tlast, send_tvalid, recv_tready, ctl_tlast, ctl_tvalid;
	logic sts_tready;
	logic send_tready = 1'b0, ctl_tready = 1'b0, sts_tvalid = 1'b0;
	logic sts_tlast = 1'b0, recv_tlast = 1'b0, recv_tvalid = 1'b0;
	logic slow = 1'b0;
	logic [31:0] recv_tdata = 32'h0000_0000, sts_tdata = 32'h0000_0000;
	// accelerator side drives full strobes and zero sidebands
	logic [3:0] recv_tstrb = 4'hF, recv_tkeep = 4'hF, recv_tuser = 4'h0;
	logic [4:0] recv_tid = 5'h00, recv_tdest = 5'h00;
	logic [31:0] seed = 32'hD1031966;
	int bad_count = 0, checked = 0, cyc = 0;
	logic [32:0] sq[$];
	logic [63:0] wq[$];
	logic [31:0] rq[$];
	logic rd_d = 1'b0;

	sdma_top sdma_top_i (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .m_araddr, .m_arlen, .m_arsize, .m_arburst,
		.m_arvalid, .m_arready, .m_rdata, .m_rresp, .m_rlast, .m_rvalid,
		.m_rready, .m_awaddr, .m_awlen, .m_awsize, .m_awburst, .m_awvalid,
		.m_awready, .m_wdata, .m_wstrb, .m_wlast, .m_wvalid, .m_wready,
		.m_bresp, .m_bvalid, .m_bready, .send_tdata, .send_tstrb, .send_tkeep,
		.send_tuser, .send_tid, .send_tdest, .send_tlast, .send_tvalid,
		.send_tready, .recv_tdata, .recv_tstrb, .recv_tkeep, .recv_tuser,
		.recv_tid, .recv_tdest, .recv_tlast, .recv_tvalid, .recv_tready,
		.ctl_tdata, .ctl_tlast, .ctl_tvalid, .ctl_tready, .sts_tdata,
		.sts_tlast, .sts_tvalid, .sts_tready);

	sdma_mem_model sdma_mem_model_i (.core_clk, .rst_b, .slow,
		.araddr(m_araddr), .arvalid(m_arvalid), .arready(m_arready),
		.rdata(m_rdata), .rresp(m_rresp), .rlast(m_rlast), .rvalid(m_rvalid),
		.rready(m_rready), .awaddr(m_awaddr), .awvalid(m_awvalid),
		.awready(m_awready), .wdata(m_wdata), .wvalid(m_wvalid),
		.wready(m_wready), .bresp(m_bresp), .bvalid(m_bvalid),
		.bready(m_bready));

	always #2 core_clk = ~core_clk;

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic results();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : results

	// one-cycle strobes with a gap so no strobe is assigned twice at an edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
	endtask : rd

	// valid stays up into the next beat; the caller lowers it at the end
	task automatic beat(input logic [31:0] d, input logic l);
		recv_tdata <= d;
		recv_tlast <= l;
		recv_tvalid <= 1'b1;
		for (int i = 0; i < 200; i++) begin
			@(posedge core_clk);
			if (recv_tready === 1'b1) break;
		end
	endtask : beat

	task automatic drain();
		for (int i = 0; i < 30000 && sq.size() + wq.size() != 0; i++) begin
			@(posedge core_clk);
		end
		check(sq.size() + wq.size(), 0);
	endtask : drain

	// random stalls of the far side, status source and the timeout
	always @(posedge core_clk) begin
		rv = rnd();
		send_tready <= rv[0] | rv[1];
		ctl_tready <= rv[2];
		sts_tvalid <= rv[3];
		sts_tlast <= rv[4];
		sts_tdata <= rv;
		slow <= rv[5] & rv[6];
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			bad_count++;
			results();
		end
	end

	// scoreboards: an empty queue pops unknown, so extra beats mismatch
	always @(posedge core_clk) begin
		rd_d <= reg_rd;
		if (rd_d) check(reg_rdata, rq.pop_front());
		if (send_tvalid && send_tready) begin
			check({send_tlast, send_tdata}, sq.pop_front());
			check({send_tstrb, send_tkeep, send_tuser, send_tid, send_tdest},
				{4'hF, 4'hF, 14'h0000});
		end
		if (m_awvalid && m_awready && m_wvalid) begin
			check({m_awaddr, m_wdata}, wq.pop_front());
		end
	end

	initial begin
		for (int k = 0; k < 2048; k++) sdma_mem_model_i.mem[k] = rnd();
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		check({m_arlen, m_arsize, m_arburst, m_wstrb, m_wlast},
			{8'h00, 3'h2, 2'h1, 4'hF, 1'b1});
		wr(sdma_pkg::OFF_SEND_SRC, 32'h0000_0100);
		rd(sdma_pkg::OFF_SEND_SRC, 32'h0000_0100);
		rd(8'h80, 32'h0000_0000);
		// both idle, no errors, chained-mode flag clear
		rd(sdma_pkg::OFF_STAT, 32'h0000_0003);
		// lengths with run bits clear must start nothing
		wr(sdma_pkg::OFF_CTRL, 32'h0000_0000);
		wr(sdma_pkg::OFF_SEND_LEN, 32'h0000_0008);
		wr(sdma_pkg::OFF_RECV_LEN, 32'h0000_0008);
		repeat (8) @(posedge core_clk);
		check({m_arvalid, recv_tready}, 2'h0);
		check({m_awlen, m_awsize, m_awburst, ctl_tvalid, ctl_tdata, sts_tready},
			{8'h00, 3'h2, 2'h1, 1'b0, 32'h0000_0000, 1'b1});
		$display("test registers done");
		// six bytes round up to two words, last on the second
		sq.push_back({1'b0, sdma_mem_model_i.mem[64]});
		sq.push_back({1'b1, sdma_mem_model_i.mem[65]});
		wr(sdma_pkg::OFF_CTRL, 32'h0000_0001);
		wr(sdma_pkg::OFF_SEND_SRC, 32'h0000_0100);
		wr(sdma_pkg::OFF_SEND_LEN, 32'h0000_0006);
		drain();
		$display("test short send done");
		// two 32x32 matrices back to back, row-major
		for (int k = 0; k < 2048; k++) begin
			sq.push_back({k == 2047, sdma_mem_model_i.mem[k]});
		end
		wr(sdma_pkg::OFF_CTRL, 32'h0000_0001);
		wr(sdma_pkg::OFF_SEND_SRC, 32'h0000_0000);
		wr(sdma_pkg::OFF_SEND_LEN, 32'h0000_2000);
		drain();
		$display("test matrix send done");
		// product matrix back into a buffer of exactly its size
		wr(sdma_pkg::OFF_CTRL, 32'h0000_0003);
		wr(sdma_pkg::OFF_RECV_DST, 32'h0000_1000);
		wr(sdma_pkg::OFF_RECV_LEN, 32'h0000_1000);
		for (int k = 0; k < 1024; k++) begin
			bv = rnd();
			wq.push_back({32'h0000_1000 + 32'(k << 2), bv});
			beat(bv, k == 1023);
		end
		recv_tvalid <= 1'b0;
		drain();
		// byte count moves on the edge the last write response is taken
		repeat (2) @(posedge core_clk);
		rd(sdma_pkg::OFF_RECV_CNT, 32'h0000_1000);
		@(posedge core_clk);
		$display("test matrix receive done");
		results();
	end
endmodule : tb_stream_dma_direct_mode
`default_nettype wire
